//--- rpc_partner.sv
// behavioural model of the external reset circuit and configuration source
`timescale 1ns/1ns
module rpc_partner #(
    parameter bit FAST_OSC = 1'h0 // oscillator runs above 12 MHz
) (
    // controls from the bench
    hold_low,
    rst_en,
    // pin and configuration into the device
    reset_pin_n,
    user_config_byte_one
);
    input wire logic hold_low; // circuit pulls the pin low
    input wire logic rst_en; // integrator picks the reset role
    output logic reset_pin_n;
    output logic [7:0] user_config_byte_one;
    // pin has a pull-up, so a released circuit reads high, never stale
    assign reset_pin_n = ~hold_low;
    // a fast oscillator forces the reset role on, whatever was asked
    assign user_config_byte_one = {1'h0, rst_en | FAST_OSC, 6'h00};
endmodule

//--- rpc_pkg.sv
// package of constants for the reset pin and port-one pin mux block
package rpc_pkg;
    // reset synchroniser depth in flip-flops
    localparam int RPC_SYNC_STAGES = 2;
    // power-on window length in cycles during which the pin is always reset
    localparam int RPC_POR_CYCLES = 16;
    // sampling cycle inside the power-on window for programming-mode entry
    localparam int RPC_ISP_SAMPLE_CYCLE = 8;
    // position of the reset-enable bit in the user configuration byte
    localparam int RPC_CFG_RST_EN_BIT = 6;
    // reserved, fixed-zero and fixed-one masks for a guarded register byte
    localparam logic [7:0] RPC_FIX0_MASK = 8'h04;
    localparam logic [7:0] RPC_FIX1_MASK = 8'h00;
    localparam logic [7:0] RPC_RSVD_MASK = 8'h32;
    // restart fetch address after reset
    localparam logic [15:0] RPC_RESET_VECTOR = 16'h0000;
    // power-on sequencer states
    typedef enum logic [1:0] {RPC_POR, RPC_RUN} rpc_state_t;
endpackage

//--- rpc_sync.sv
// two-flop synchroniser for the external reset pin
`timescale 1ns/1ns
module rpc_sync
    import rpc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // carrier
    rpc_sync_if.dst sif
);
    logic meta_q;   // first stage, read only by the second
    logic clean_q;  // second stage

    // reset preset high so the pin is seen inactive until sampled
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= 1'b1;
            clean_q <= 1'b1;
        end else begin
            meta_q <= sif.raw_n;
            clean_q <= meta_q;
        end
    end
    assign sif.clean_n = clean_q;
endmodule

//--- rpc_sync_if.sv
// interface carrying the synchronised reset pin between modules
`timescale 1ns/1ns
interface rpc_sync_if;
    logic raw_n;    // pin level into the synchroniser
    logic clean_n;  // synchronised level out
    modport src (output raw_n, input clean_n);
    modport dst (input raw_n, output clean_n);
endinterface

//--- rpc_top.sv
// reset pin function, port one pin roles and guarded register bit rules
//
// Summary of operation
// - low reset pin resets core, fetch zero
// - pin is reset at power-on or configured
// - pin sampled at power-on for programming
// - otherwise pin is input-only port bit
// - port bit two serves timer zero
// - port bit one feeds serial receive
// - reserved bits written zero, read anything
// - fixed-zero bits always read zero
// - fixed-one bits always read one
`timescale 1ns/1ns
module rpc_top
    import rpc_pkg::*;
#(
    parameter int POR_CYCLES = RPC_POR_CYCLES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // shared reset pin and configuration
    input wire logic reset_pin_n,
    input wire logic [7:0] user_config_byte_one,
    // timer zero pin role
    input wire logic timer_zero_out_en,
    input wire logic timer_zero_out,
    input wire logic port1_bit2_pin_in,
    // serial receive pin
    input wire logic port1_bit1_pin,
    // guarded register byte path
    input wire logic [7:0] sfr_wr_data,
    input wire logic [7:0] sfr_rd_raw,
    // outputs to the core
    output logic core_reset,
    output logic [15:0] fetch_addr_reset,
    output logic isp_entry,
    output logic port1_bit5_input,
    output logic timer_zero_pin,
    output logic port1_bit2_pin_out,
    output logic port1_bit2_pin_oe,
    output logic serial_rx_data,
    output logic [7:0] sfr_rd_data,
    output logic [7:0] sfr_wr_clean
);
    rpc_sync_if sif();
    rpc_state_t state_q, state_d;
    logic [7:0] por_cnt_q, por_cnt_d;   // power-on window counter
    logic reset_func;                   // pin acts as reset now
    logic pin_low;                      // synchronised pin is low
    logic isp_q;                        // latched programming request
    logic pin_reset;                    // pin is asserting reset right now
    logic por_last;                     // last count of the power-on window
    logic isp_sample;                   // sampling point for programming entry
    logic oe_allowed;                   // timer may drive bit two this cycle
    logic [7:0] rd_forced;              // read byte with fixed bits forced
    logic [7:0] wr_forced;              // write byte with protected bits cleaned

    // synchroniser on the pin; its first stage stays private
    assign sif.raw_n = reset_pin_n;
    rpc_sync rpc_sync_i (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .sif(sif)
    );

    // reset function selection: always during power-on, else by config bit
    assign reset_func = (state_q == RPC_POR) || user_config_byte_one[RPC_CFG_RST_EN_BIT];
    assign pin_low = ~sif.clean_n;

    // reset from the pin only while the pin holds the reset role
    assign pin_reset = reset_func && pin_low;
    // window ends on its last count; the counter then freezes
    assign por_last = 32'(por_cnt_q) >= POR_CYCLES - 1;
    // one sampling point only, so a bouncing pin cannot toggle the request
    assign isp_sample = (state_q == RPC_POR) && (32'(por_cnt_q) == RPC_ISP_SAMPLE_CYCLE);
    // ports fall back to input-only while reset is applied
    assign oe_allowed = timer_zero_out_en && !pin_reset;
    // fixed bits forced on read; reserved bits passed raw, any value allowed
    assign rd_forced = (sfr_rd_raw & ~RPC_FIX0_MASK) | RPC_FIX1_MASK;
    // reserved and fixed-zero bits cleared, fixed-one bits set on write
    assign wr_forced = (sfr_wr_data & ~(RPC_FIX0_MASK | RPC_RSVD_MASK)) | RPC_FIX1_MASK;

    // power-on sequencer
    always_comb begin
        state_d = state_q;
        por_cnt_d = por_cnt_q;
        case (state_q)
            RPC_POR: begin
                por_cnt_d = por_cnt_q + 8'h01;
                if (por_last) begin
                    state_d = RPC_RUN;
                end
            end
            RPC_RUN: begin
                por_cnt_d = por_cnt_q;
            end
            default: begin
                state_d = RPC_POR;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= RPC_POR;
            por_cnt_q <= 8'h00;
        end else begin
            state_q <= state_d;
            por_cnt_q <= por_cnt_d;
        end
    end

    // programming entry caught while pin is held low in the window
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            isp_q <= 1'b0;
        end else if (isp_sample) begin
            isp_q <= pin_low;
        end
    end

    // registered outputs; reset output is driven on the clean edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_reset <= 1'b1;
            fetch_addr_reset <= RPC_RESET_VECTOR;
            isp_entry <= 1'b0;
            port1_bit5_input <= 1'b1;
            timer_zero_pin <= 1'b0;
            port1_bit2_pin_out <= 1'b0;
            port1_bit2_pin_oe <= 1'b0;
            serial_rx_data <= 1'b1;
            sfr_rd_data <= 8'h00;
            sfr_wr_clean <= 8'h00;
        end else begin
            core_reset <= pin_reset;
            fetch_addr_reset <= RPC_RESET_VECTOR;
            isp_entry <= isp_q;
            // pin reads as plain input only when not reset; never driven
            port1_bit5_input <= reset_func ? 1'b1 : sif.clean_n;
            timer_zero_pin <= port1_bit2_pin_in;
            port1_bit2_pin_out <= timer_zero_out;
            port1_bit2_pin_oe <= oe_allowed;
            serial_rx_data <= port1_bit1_pin;
            // fixed bits forced on read; reserved bits passed as raw
            sfr_rd_data <= rd_forced;
            sfr_wr_clean <= wr_forced;
        end
    end

    // checks
    rst_follow_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (reset_func && pin_low) |=> core_reset) else $error("reset not asserted");
    rst_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == RPC_RUN && !user_config_byte_one[RPC_CFG_RST_EN_BIT]) |=> !core_reset)
        else $error("reset while disabled");
    vec_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        core_reset |-> fetch_addr_reset == 16'h0000) else $error("vector not zero");
    sync_lat_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(reset_pin_n) && reset_func ##1 reset_func ##1 reset_func |=> core_reset)
        else $error("sync latency wrong");
    // once the window is over the programming request must not move
    isp_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_q == RPC_RUN |=> $stable(isp_entry))
        else $error("isp changed");
    // the request takes the pin level seen at the sampling point
    isp_latch_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        isp_sample |=> isp_q == $past(pin_low))
        else $error("isp not latched");
    // the window must end on its last count
    por_end_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == RPC_POR && por_last) |=> state_q == RPC_RUN)
        else $error("window did not end");
    bit5_in_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !reset_func |=> port1_bit5_input == $past(sif.clean_n)) else $error("bit5 wrong");
    t0_path_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> port1_bit2_pin_oe == $past(timer_zero_out_en && !pin_reset))
        else $error("t0 oe");
    // the timer pin role passes both ways in one edge
    tz_path_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> timer_zero_pin == $past(port1_bit2_pin_in)) else $error("t0 in");
    pout_path_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> port1_bit2_pin_out == $past(timer_zero_out)) else $error("t0 out");
    // a port pin must never be driven while the core sits in reset
    oe_rst_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        core_reset |-> !port1_bit2_pin_oe) else $error("pin driven in reset");
    // while the pin is reset it must not leak into the input bit
    bit5_rst_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        reset_func |=> port1_bit5_input) else $error("bit5 leaked");
    rx_path_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> serial_rx_data == $past(port1_bit1_pin)) else $error("rx path");
    fix_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sfr_rd_data & RPC_FIX0_MASK) == 8'h00) else $error("fixed zero read");
    fix_one_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sfr_rd_data & RPC_FIX1_MASK) == RPC_FIX1_MASK) else $error("fixed one read");
    rsvd_wr_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sfr_wr_clean & RPC_RSVD_MASK) == 8'h00) else $error("reserved written");
    // writes also keep the fixed bits at their fixed values
    wr_fix0_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sfr_wr_clean & RPC_FIX0_MASK) == 8'h00) else $error("fixed zero written");
    wr_fix1_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (sfr_wr_clean & RPC_FIX1_MASK) == RPC_FIX1_MASK) else $error("fixed one written");
    // main scenarios worth seeing at least once
    por_rst_c: cover property (@(posedge core_clk) state_q == RPC_POR && core_reset);
    isp_c: cover property (@(posedge core_clk) isp_entry);
    run_rst_c: cover property (@(posedge core_clk) state_q == RPC_RUN && core_reset);
    oe_drive_c: cover property (@(posedge core_clk) port1_bit2_pin_oe && !core_reset);
endmodule

//--- rpc_top_test.sv
// self-checking bench for the reset pin and port one pin roles
`timescale 1ns/1ns
module rpc_top_test;
    import rpc_pkg::*;
    localparam int POR = 12; // short window, still past the sample point
    logic core_clk = 0, sys_rst = 1, hold_low = 0, rst_en = 0; // bench controls
    logic en = 0, tout = 0, p12 = 0, p11 = 1; // pin roles
    logic [7:0] wr = 8'h00, raw = 8'h00; // register byte path
    logic reset_pin_n, core_reset, isp_entry, bit5, oe, pout, tz, rx;
    logic [7:0] cfg, rd, wrc;
    logic [15:0] fetch;
    int bad_count = 0, cmp_count = 0, cyc = 0;
    // rows: {en, out, p12, p11, wr, raw} beside {oe, out, tz, rx, rd, wr_clean}
    logic [19:0] tin [4] = '{20'hcffff, 20'h30000, 20'ha3604, 20'h5c932};
    logic [19:0] texp [4] = '{20'hcfbc9, 20'h30000, 20'ha0000, 20'h532c9};
    rpc_partner rpc_partner_i (.hold_low(hold_low), .rst_en(rst_en),
        .reset_pin_n(reset_pin_n), .user_config_byte_one(cfg));
    rpc_top #(.POR_CYCLES(POR)) rpc_top_i (.core_clk(core_clk), .sys_rst(sys_rst),
        .reset_pin_n(reset_pin_n), .user_config_byte_one(cfg), .timer_zero_out_en(en),
        .timer_zero_out(tout), .port1_bit2_pin_in(p12), .port1_bit1_pin(p11),
        .sfr_wr_data(wr), .sfr_rd_raw(raw), .core_reset(core_reset),
        .fetch_addr_reset(fetch), .isp_entry(isp_entry), .port1_bit5_input(bit5),
        .timer_zero_pin(tz), .port1_bit2_pin_out(pout), .port1_bit2_pin_oe(oe),
        .serial_rx_data(rx), .sfr_rd_data(rd), .sfr_wr_clean(wrc));
    // 100 MHz clock
    always #5 core_clk = ~core_clk;
    // hang guard, well past the expected run length
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            bad_count++;
            summarize();
        end
    end
    // one compare for every kind of value, widened to sixteen bits
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // wait n edges, then step off the edge so outputs have settled
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        // reset held three cycles; outputs sit at their defaults
        tick(3);
        chk("core_reset", 16'h1, core_reset);
        chk("bit5", 16'h1, bit5);
        chk("isp", 16'h0, isp_entry);
        @(posedge core_clk) sys_rst <= 0;
        tick(POR + 6);
        chk("core_reset", 16'h0, core_reset);
        chk("isp", 16'h0, isp_entry);
        chk("fetch", 16'h0000, fetch);
        $display("test reset done");
        // pin roles and guarded bits, one edge per path
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk) {en, tout, p12, p11, wr, raw} <= tin[i];
            tick(2);
            chk("rows", texp[i][15:0], {rd, wrc});
            chk("pins", {12'h000, texp[i][19:16]}, {12'h000, oe, pout, tz, rx});
        end
        $display("test rows done");
        // reset role not selected: a low pin is only an input bit
        @(posedge core_clk) hold_low <= 1;
        tick(6);
        chk("core_reset", 16'h0, core_reset);
        chk("bit5", 16'h0, bit5);
        @(posedge core_clk) hold_low <= 0;
        $display("test input role done");
        // reset role selected: three edges through the synchroniser
        @(posedge core_clk) rst_en <= 1;
        tick(6);
        @(posedge core_clk) begin
            hold_low <= 1;
            en <= 1;
        end
        tick(2);
        chk("core_reset", 16'h0, core_reset);
        tick(1);
        chk("core_reset", 16'h1, core_reset);
        chk("fetch", 16'h0000, fetch);
        chk("oe", 16'h0, oe);
        @(posedge core_clk) hold_low <= 0;
        tick(5);
        chk("core_reset", 16'h0, core_reset);
        chk("oe", 16'h1, oe);
        $display("test reset role done");
        // pin low across the power-on window forces programming entry
        @(posedge core_clk) begin
            sys_rst <= 1;
            hold_low <= 1;
        end
        tick(3);
        @(posedge core_clk) sys_rst <= 0;
        tick(POR + 6);
        chk("isp", 16'h1, isp_entry);
        @(posedge core_clk) hold_low <= 0;
        tick(6);
        chk("core_reset", 16'h0, core_reset);
        $display("test isp done");
        summarize();
    end
endmodule
